/* hdl/srx_tdm_top.v */
// Receiver auxiliary TDM output: control register, clock choice, slot builder
//
// Behaviour
// - The pin select field is one-hot and picks exactly one of four serial data outputs.
// - A pin select of zero, the reset value, drives no TDM stream on any output.
// - Clock select 0, the reset value, clocks the port from the recovered receiver clocks.
// - Clock select 1 clocks the port from filtered clock generator three instead.
// - Slots 0 and 4 carry 24 audio bits then zeros; slots 3 and 6 are all zeros.
// - Slots 1 and 5 carry 20 zeros, parity, validity, user, status, then zeros.
// - Slot 2 carries compression and audio type at bits 22 and 23; slot 7 the block start.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "srx_tdm_defs.vh"
module srx_tdm_top (
  input  wire                      clock,
  input  wire                      sys_rst,
  input  wire [`SRX_ADDR_W-1:0]    reg_addr,
  input  wire [`SRX_DATA_W-1:0]    reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [`SRX_DATA_W-1:0]    reg_rdata,
  input  wire                      dec_valid,
  output wire                      dec_ready,
  input  wire [`SRX_AUDIO_W-1:0]   dec_left_audio,
  input  wire [`SRX_AUDIO_W-1:0]   dec_right_audio,
  input  wire [3:0]                dec_left_aux,
  input  wire [3:0]                dec_right_aux,
  input  wire                      dec_compr_type,
  input  wire                      dec_audio_type,
  input  wire                      dec_block_start,
  input  wire                      rec_bit_clock,
  input  wire                      rec_frame_clock,
  input  wire                      gen3_bit_clock,
  input  wire                      gen3_frame_clock,
  output reg  [`SRX_PORTS-1:0]     serial_data_out_pin,
  output reg  [`SRX_PORTS-1:0]     serial_data_out_en,
  output reg  [`SRX_PORTS-1:0]     bit_clock_out_pin,
  output reg  [`SRX_PORTS-1:0]     frame_clock_out_pin
);

  // Control and status state
  reg  [`SRX_PIN_SEL_MSB:0]  pin_sel_reg;
  reg                        clk_sel_reg;
  reg                        underrun_reg;
  reg                        underrun_next;
  reg  [`SRX_PORTS-1:0]      route_next;

  // Link clock sampling
  wire [3:0]                 clk_sync;
  reg                        bclk_sel;
  reg                        fclk_sel;
  reg                        bclk_prev_reg;
  reg                        fclk_seen_reg;
  wire                       bclk_rise;
  wire                       bclk_fall;

  // Frame serialiser
  reg  [`SRX_BITCNT_W-1:0]   bit_cnt_reg;
  reg  [`SRX_WORD_W-1:0]     frame_reg;
  reg                        start_pend_reg;
  reg                        sdata_bit;
  wire [2:0]                 slot;
  wire [4:0]                 pos;
  wire [`SRX_AUDIO_W-1:0]    aud_l;
  wire [`SRX_AUDIO_W-1:0]    aud_r;
  wire [3:0]                 aux_l;
  wire [3:0]                 aux_r;

  // FIFO
  wire [`SRX_WORD_W-1:0]     fifo_in;
  wire [`SRX_WORD_W-1:0]     fifo_out;
  wire                       fifo_out_valid;
  wire                       fifo_empty;
  wire                       frame_load;
  wire                       active;

  // Per-port next values
  wire [`SRX_PORTS-1:0]      en_next;
  wire [`SRX_PORTS-1:0]      bclk_next;
  wire [`SRX_PORTS-1:0]      fclk_next;
  wire [`SRX_PORTS-1:0]      data_next;

  // Decoded frame packed into one FIFO word
  assign fifo_in = {dec_block_start, dec_audio_type, dec_compr_type,
                    dec_right_aux, dec_left_aux, dec_right_audio, dec_left_audio};

  // Absorbs bursts from the decoder; back-pressure reaches it through dec_ready
  srx_tdm_fifo #(
    .W     (`SRX_WORD_W),
    .DEPTH (`SRX_FIFO_DEPTH),
    .AW    (`SRX_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_data   (fifo_in),
    .in_valid  (dec_valid),
    .in_ready  (dec_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (frame_load),
    .empty     (fifo_empty)
  );

  // Both clock pairs come from outside this domain
  srx_tdm_sync #(
    .W (4)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({gen3_frame_clock, gen3_bit_clock, rec_frame_clock, rec_bit_clock}),
    .sync_out (clk_sync)
  );

  // Clock source choice
  always @* begin
    if (clk_sel_reg) begin
      bclk_sel = clk_sync[2];
      fclk_sel = clk_sync[3];
    end else begin
      bclk_sel = clk_sync[0];
      fclk_sel = clk_sync[1];
    end
  end

  assign bclk_rise = bclk_sel && !bclk_prev_reg;
  assign bclk_fall = !bclk_sel && bclk_prev_reg;

  // Only a clean one-hot value routes; anything else is off
  always @* begin
    case (pin_sel_reg)
      4'h1:    route_next = 4'h1;
      4'h2:    route_next = 4'h2;
      4'h4:    route_next = 4'h4;
      4'h8:    route_next = 4'h8;
      default: route_next = 4'h0;
    endcase
  end

  assign active = (route_next != `SRX_PIN_OFF);

  // A new frame is taken at the first falling bit clock after the frame clock rose
  assign frame_load = bclk_fall && start_pend_reg;

  // Slot number and bit position within the slot, MSB first
  assign slot  = bit_cnt_reg[7:5];
  assign pos   = bit_cnt_reg[4:0];

  // Fields of the held frame word
  assign aud_l = frame_reg[`SRX_W_LEFT_LSB +: `SRX_AUDIO_W];
  assign aud_r = frame_reg[`SRX_W_RIGHT_LSB +: `SRX_AUDIO_W];
  assign aux_l = frame_reg[`SRX_W_LAUX_LSB +: 4];
  assign aux_r = frame_reg[`SRX_W_RAUX_LSB +: 4];

  // Bit picked from the held frame for the current slot position
  always @* begin
    sdata_bit = 1'b0;
    case (slot)
      `SRX_SLOT_LEFT: begin
        if (pos < `SRX_POS_AUD_END) sdata_bit = aud_l[`SRX_POS_AUD_MSB - pos];
      end
      `SRX_SLOT_RIGHT: begin
        if (pos < `SRX_POS_AUD_END) sdata_bit = aud_r[`SRX_POS_AUD_MSB - pos];
      end
      `SRX_SLOT_LAUX: begin
        if (pos >= `SRX_POS_AUX0 && pos < `SRX_POS_AUD_END)
          sdata_bit = aux_l[2'h3 - pos[1:0]];
      end
      `SRX_SLOT_RAUX: begin
        if (pos >= `SRX_POS_AUX0 && pos < `SRX_POS_AUD_END)
          sdata_bit = aux_r[2'h3 - pos[1:0]];
      end
      `SRX_SLOT_CODEC: begin
        if (pos == `SRX_POS_CTYPE) sdata_bit = frame_reg[`SRX_W_CTYPE];
        if (pos == `SRX_POS_ATYPE) sdata_bit = frame_reg[`SRX_W_ATYPE];
      end
      `SRX_SLOT_BLOCK: begin
        if (pos == `SRX_POS_BLOCK) sdata_bit = frame_reg[`SRX_W_BLOCK];
      end
      default: sdata_bit = 1'b0;
    endcase
  end

  // Underrun: frame start with nothing queued sends zeros; set wins over clear
  always @* begin
    underrun_next = underrun_reg;
    if (reg_wr && reg_addr == `SRX_ADDR_STATUS && reg_wdata[`SRX_ST_UNDERRUN])
      underrun_next = 1'b0;
    if (frame_load && !fifo_out_valid)
      underrun_next = 1'b1;
  end

  // Underrun flag register
  always @(posedge clock) begin
    if (sys_rst) begin
      underrun_reg <= 1'b0;
    end else begin
      underrun_reg <= underrun_next;
    end
  end

  // Register writes
  always @(posedge clock) begin
    if (sys_rst) begin
      pin_sel_reg <= `SRX_PIN_OFF;
      clk_sel_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SRX_ADDR_CTRL) begin
        pin_sel_reg <= reg_wdata[`SRX_PIN_SEL_MSB:`SRX_PIN_SEL_LSB];
        clk_sel_reg <= reg_wdata[`SRX_CLK_SEL_BIT];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads return zero
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SRX_ADDR_CTRL:   reg_rdata <= {11'h000, clk_sel_reg, pin_sel_reg};
        `SRX_ADDR_STATUS: reg_rdata <= {13'h0000, underrun_reg, fifo_empty, active};
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Bit clock edge detector works on the synchronised copy only
  always @(posedge clock) begin
    if (sys_rst) begin
      bclk_prev_reg <= 1'b0;
    end else begin
      bclk_prev_reg <= bclk_sel;
    end
  end

  // Frame clock is sampled on the rising bit clock, where the far side keeps it stable
  always @(posedge clock) begin
    if (sys_rst) begin
      fclk_seen_reg  <= 1'b0;
      start_pend_reg <= 1'b0;
    end else begin
      if (bclk_rise) begin
        fclk_seen_reg <= fclk_sel;
        if (fclk_sel && !fclk_seen_reg) start_pend_reg <= 1'b1;
      end
      if (frame_load) begin
        start_pend_reg <= 1'b0;
      end
    end
  end

  // Counter steps on the falling bit clock; a frame start restarts it and loads a word
  always @(posedge clock) begin
    if (sys_rst) begin
      bit_cnt_reg <= 8'h00;
      frame_reg   <= {`SRX_WORD_W{1'b0}};
    end else if (frame_load) begin
      bit_cnt_reg <= 8'h00;
      frame_reg   <= fifo_out_valid ? fifo_out : {`SRX_WORD_W{1'b0}}; // Empty queue sends silence
    end else if (bclk_fall) begin
      bit_cnt_reg <= bit_cnt_reg + 8'h01;
    end
  end

  // Per-port next values: only the routed port sees data and clocks
  genvar gi;
  generate
    for (gi = 0; gi < `SRX_PORTS; gi = gi + 1) begin : g_port
      assign en_next[gi]   = route_next[gi];
      assign bclk_next[gi] = route_next[gi] & bclk_sel;
      assign fclk_next[gi] = route_next[gi] & fclk_sel;
      assign data_next[gi] = route_next[gi] & sdata_bit & ~frame_load;
    end
  endgenerate

  // Data changes on the falling bit clock; a port that loses its route drops at once
  always @(posedge clock) begin
    if (sys_rst) begin
      serial_data_out_pin <= 4'h0;
    end else if (bclk_fall) begin
      serial_data_out_pin <= data_next;
    end else begin
      serial_data_out_pin <= serial_data_out_pin & en_next;
    end
  end

  // Enable and clocks follow the route with one register stage
  always @(posedge clock) begin
    if (sys_rst) begin
      serial_data_out_en  <= 4'h0;
      bit_clock_out_pin   <= 4'h0;
      frame_clock_out_pin <= 4'h0;
    end else begin
      serial_data_out_en  <= en_next;
      bit_clock_out_pin   <= bclk_next;
      frame_clock_out_pin <= fclk_next;
    end
  end

endmodule

/* shared/srx_tdm_defs.vh */
// Constants for the receiver auxiliary TDM output block
`ifndef SRX_TDM_DEFS_VH
`define SRX_TDM_DEFS_VH

// Register bus
`define SRX_ADDR_W        4
`define SRX_DATA_W        16
`define SRX_ADDR_CTRL     4'h0
`define SRX_ADDR_STATUS   4'h1

// Control register fields
`define SRX_PIN_SEL_MSB   3
`define SRX_PIN_SEL_LSB   0
`define SRX_CLK_SEL_BIT   4
`define SRX_CTRL_RESET    5'h00
`define SRX_PIN_OFF       4'h0

// Status register fields
`define SRX_ST_ACTIVE     0
`define SRX_ST_EMPTY      1
`define SRX_ST_UNDERRUN   2

// Output ports
`define SRX_PORTS         4

// TDM frame layout
`define SRX_AUDIO_W       24
`define SRX_SLOT_W        32
`define SRX_BITCNT_W      8
`define SRX_SLOT_LEFT     3'h0
`define SRX_SLOT_LAUX     3'h1
`define SRX_SLOT_CODEC    3'h2
`define SRX_SLOT_RIGHT    3'h4
`define SRX_SLOT_RAUX     3'h5
`define SRX_SLOT_BLOCK    3'h7
`define SRX_POS_AUX0      5'h14
`define SRX_POS_CTYPE     5'h16
`define SRX_POS_ATYPE     5'h17
`define SRX_POS_BLOCK     5'h17
`define SRX_POS_AUD_MSB   5'h17
`define SRX_POS_AUD_END   5'h18

// Frame word held in the FIFO
`define SRX_WORD_W        59
`define SRX_FIFO_DEPTH    16
`define SRX_FIFO_AW       4
`define SRX_W_LEFT_LSB    0
`define SRX_W_RIGHT_LSB   24
`define SRX_W_LAUX_LSB    48
`define SRX_W_RAUX_LSB    52
`define SRX_W_CTYPE       56
`define SRX_W_ATYPE       57
`define SRX_W_BLOCK       58

`endif

/* hdl/srx_tdm_sync.v */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module srx_tdm_sync #(
  parameter W = 1
) (
  input  wire         clock,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* hdl/srx_tdm_fifo.v */
// Frame FIFO with registered read data, valid and ready on both sides
`timescale 1ns/1ps
module srx_tdm_fifo #(
  parameter W     = 59,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clock,
  input  wire         sys_rst,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output reg          in_ready,
  output reg  [W-1:0] out_data,
  output reg          out_valid,
  input  wire         out_ready,
  output wire         empty
);

  localparam [AW:0] FULL = DEPTH;

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;
  reg [AW:0]   count_next;
  wire         push;
  wire         pop;

  // Full when all entries are taken; output register counts separately
  assign push     = in_valid && in_ready;
  assign pop      = (count_reg != {(AW+1){1'b0}}) && (!out_valid || out_ready);
  assign empty    = !out_valid && (count_reg == {(AW+1){1'b0}});

  // Entry count after this cycle; ready is registered from it so the port is a flop
  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Storage array, written only on push
  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers, count and output register
  always @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      in_ready   <= 1'b0;
      out_valid  <= 1'b0;
      out_data   <= {W{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
        out_data   <= mem[rd_ptr_reg];
        out_valid  <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      count_reg <= count_next;
      in_ready  <= (count_next != FULL);
    end
  end

endmodule

/* tb/srx_tdm_checker.sv */
// Port-level assertions for the receiver auxiliary TDM output block
`timescale 1ns/1ps
`include "srx_tdm_defs.vh"
module srx_tdm_checker (
  input wire                   clock,
  input wire                   sys_rst,
  input wire [`SRX_ADDR_W-1:0] reg_addr,
  input wire [`SRX_DATA_W-1:0] reg_wdata,
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [`SRX_DATA_W-1:0] reg_rdata,
  input wire                   rec_bit_clock,
  input wire                   gen3_bit_clock,
  input wire [`SRX_PORTS-1:0]  serial_data_out_pin,
  input wire [`SRX_PORTS-1:0]  serial_data_out_en,
  input wire [`SRX_PORTS-1:0]  bit_clock_out_pin,
  input wire [`SRX_PORTS-1:0]  frame_clock_out_pin
);
  reg  [4:0] ctl_reg;
  reg  [2:0] age_reg;
  wire [3:0] sel   = ctl_reg[3:0];
  wire       hot   = (sel != 4'h0) && ((sel & (sel - 4'h1)) == 4'h0);
  wire       calm  = (age_reg == 3'h7);
  wire [3:0] route = hot ? sel : 4'h0;
  // Shadow of the control word; pins lag a write by the control and output registers, so wait until calm
  always @(posedge clock) begin
    if (sys_rst || (reg_wr && reg_addr == `SRX_ADDR_CTRL)) begin
      ctl_reg <= sys_rst ? `SRX_CTRL_RESET : reg_wdata[4:0];
      age_reg <= 3'h0;
    end else if (!calm) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_SINGLE_EN: assert property ($onehot0(serial_data_out_en))
    else $error("several data outputs enabled");
  AST_ROUTE_EN: assert property (calm |-> serial_data_out_en == route)
    else $error("data enable does not follow pin select");
  AST_DATA_ROUTED: assert property (calm |-> (serial_data_out_pin & ~route) == 4'h0)
    else $error("data on an output that is not routed");
  AST_IDLE_PINS: assert property (calm && !hot |->
    (serial_data_out_pin | bit_clock_out_pin | frame_clock_out_pin) == 4'h0)
    else $error("pins active while output disabled");
  AST_REC_BCLK: assert property (calm && hot && !ctl_reg[4] |->
    bit_clock_out_pin == ({4{$past(rec_bit_clock, 3)}} & sel))
    else $error("bit clock does not follow recovered clock");
  AST_GEN_BCLK: assert property (calm && hot && ctl_reg[4] |->
    bit_clock_out_pin == ({4{$past(gen3_bit_clock, 3)}} & sel))
    else $error("bit clock does not follow generator clock");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  AST_CTL_READ: assert property ($past(reg_rd) && $past(reg_addr) == `SRX_ADDR_CTRL |->
    reg_rdata == {11'h000, $past(ctl_reg)})
    else $error("control read back wrong");
endmodule

/* tb/srx_tdm_sink.sv */
// Downstream TDM receiver model: gathers each 256-bit frame, MSB first
`timescale 1ns/1ps
module srx_tdm_sink (
  input wire          bclk,
  input wire          fclk,
  input wire          sdata,
  output reg  [255:0] frame_bits,
  output reg  [15:0]  frame_cnt
);
  reg [255:0] shift_reg = 256'h0;
  reg [8:0]   pos_reg = 9'h1FF;
  reg         fclk_reg = 1'b1;
  reg         full_reg = 1'b0;
  initial frame_bits = 256'h0;
  initial frame_cnt = 16'h0000;
  // Sample on rising bit clock; data lag two bits, so a frame's last bit follows the next edge
  always @(posedge bclk) begin
    fclk_reg <= fclk;
    full_reg <= (pos_reg == 9'h0FF);
    if (fclk && !fclk_reg)
      pos_reg <= 9'h000;
    else if (pos_reg != 9'h1FF)
      pos_reg <= pos_reg + 9'h001;
    if (pos_reg != 9'h1FF)
      shift_reg <= {shift_reg[254:0], sdata};
    if (pos_reg == 9'h000 && full_reg) begin
      frame_bits <= {shift_reg[254:0], sdata};
      frame_cnt <= frame_cnt + 16'h0001;
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the receiver auxiliary TDM output block
`timescale 1ns/1ps
`include "srx_tdm_defs.vh"
module tb;
  reg          clock = 1'b0;
  reg          sys_rst = 1'b1;
  reg  [3:0]   reg_addr = 4'h0;
  reg  [15:0]  reg_wdata = 16'h0000;
  reg          reg_wr = 1'b0;
  reg          reg_rd = 1'b0;
  reg          dec_valid = 1'b0;
  reg  [58:0]  dw = 59'h0;
  reg          rbc = 1'b0;
  reg          rfc = 1'b0;
  reg          gbc = 1'b0;
  reg          gfc = 1'b0;
  reg  [1:0]   port = 2'h0;
  integer      rn = 0;
  integer      gn = 0;
  integer      error_cnt = 0;
  integer      n_tests = 0;
  wire [15:0]  reg_rdata;
  wire         dec_ready;
  wire [3:0]   sd_pin, sd_en, bc_pin, fc_pin;
  wire [255:0] rx_frame;
  wire [15:0]  rx_cnt;
  // System clock and two free-running link clock sets of equal rate, the generator set a quarter period behind
  always #4 clock = ~clock;
  always #32 rbc = ~rbc;
  initial #16 forever #32 gbc = ~gbc;
  always @(negedge rbc) begin
    rn = (rn + 1) % 256;
    rfc = (rn < 32);
  end
  always @(negedge gbc) begin
    gn = (gn + 1) % 256;
    gfc = (gn < 32);
  end
  srx_tdm_top uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .dec_left_audio(dw[23:0]), .dec_right_audio(dw[47:24]),
    .dec_left_aux(dw[51:48]), .dec_right_aux(dw[55:52]), .dec_compr_type(dw[56]),
    .dec_audio_type(dw[57]), .dec_block_start(dw[58]), .rec_bit_clock(rbc),
    .rec_frame_clock(rfc), .gen3_bit_clock(gbc), .gen3_frame_clock(gfc),
    .serial_data_out_pin(sd_pin), .serial_data_out_en(sd_en), .bit_clock_out_pin(bc_pin),
    .frame_clock_out_pin(fc_pin));
  srx_tdm_sink sink (.bclk(bc_pin[port]), .fclk(fc_pin[port]), .sdata(sd_pin[port]),
    .frame_bits(rx_frame), .frame_cnt(rx_cnt));
  // Expected frame: eight 32-bit slots, MSB first
  function [255:0] exp_frame(input [58:0] w);
    exp_frame = {w[23:0], 8'h00, 20'h00000, w[51:48], 8'h00, 22'h000000, w[56], w[57], 8'h00,
      32'h0, w[47:24], 8'h00, 20'h00000, w[55:52], 8'h00, 32'h0, 23'h000000, w[58], 8'h00};
  endfunction
  task chk(input [255:0] got, input [255:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task end_sim;
    begin
      if (error_cnt == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
    end
  endtask
  task rd_chk(input [3:0] a, input [15:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      chk(reg_rdata, e);
    end
  endtask
  // Wait for the receiver model to complete a frame; a fresh route may need two frames
  task next_frame;
    reg [15:0] c0;
    integer k;
    begin
      c0 = rx_cnt;
      k = 0;
      while (rx_cnt === c0 && k < 4400) begin
        @(posedge clock);
        k = k + 1;
      end
      chk(k < 4400, 1);
    end
  endtask
  task t_regs;
    begin
      chk({sd_pin, sd_en, bc_pin, fc_pin}, 256'h0);
      rd_chk(`SRX_ADDR_CTRL, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rd_chk(4'hF, 16'h0000);
      rd_chk(`SRX_ADDR_CTRL, 16'h0000);
      wr(`SRX_ADDR_CTRL, 16'hFFFF);
      rd_chk(`SRX_ADDR_CTRL, 16'h001F);
      repeat (8) @(posedge clock);
      chk(sd_en | sd_pin, 256'h0);
      wr(`SRX_ADDR_CTRL, 16'h0003);
      repeat (8) @(posedge clock);
      chk(sd_en | sd_pin, 256'h0);
    end
  endtask
  // Route one port, send one frame word, then expect an all-zero underrun frame
  task t_route(input [1:0] p, input cs);
    reg [58:0] w;
    integer k;
    begin
      case (p)
        2'h0: w = {59{1'b1}};
        2'h1: w = {3'b101, 4'hA, 4'h5, 24'h800001, 24'h123456};
        2'h2: w = {3'b010, 4'h1, 4'h8, 24'hFFFFFF, 24'h000001};
        default: w = {3'b100, 4'hF, 4'h0, 24'hA5A5A5, 24'h5A5A5A};
      endcase
      port <= p;
      wr(`SRX_ADDR_CTRL, {11'h000, cs, 4'h1 << p});
      next_frame;
      next_frame;
      chk(sd_en, 4'h1 << p);
      dw <= w;
      dec_valid <= 1'b1;
      @(posedge clock);
      dec_valid <= 1'b0;
      k = 0;
      next_frame;
      while (rx_frame === 256'h0 && k < 3) begin
        next_frame;
        k = k + 1;
      end
      chk(rx_frame, exp_frame(w));
      next_frame;
      chk(rx_frame, 256'h0);
      rd_chk(`SRX_ADDR_STATUS, 16'h0007);
    end
  endtask
  // Fill the frame queue until it refuses, then let the link drain it
  task t_fill;
    integer n;
    integer k;
    begin
      n = 0;
      dec_valid <= 1'b1;
      dw <= 59'h1;
      @(posedge clock);
      while (dec_ready === 1'b1 && n < 40) begin
        n = n + 1;
        dw <= dw + 59'h1;
        @(posedge clock);
      end
      dec_valid <= 1'b0;
      chk(n >= 17 && n <= 18, 1);
      wr(`SRX_ADDR_STATUS, 16'h0004);
      rd_chk(`SRX_ADDR_STATUS, 16'h0001);
      for (k = 0; k < 20; k = k + 1)
        next_frame;
      rd_chk(`SRX_ADDR_STATUS, 16'h0007);
      chk(dec_ready, 1);
    end
  endtask
  // Watchdog sized for about forty-seven frames
  initial begin
    #(8 * 96000);
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_route(2'h0, 1'b0);
    t_route(2'h1, 1'b1);
    t_route(2'h2, 1'b0);
    t_route(2'h3, 1'b1);
    t_fill;
    wr(`SRX_ADDR_CTRL, 16'h0000);
    repeat (8) @(posedge clock);
    chk({sd_en, sd_pin, bc_pin, fc_pin}, 256'h0);
    end_sim;
  end
endmodule
bind srx_tdm_top srx_tdm_checker chk (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rec_bit_clock, .gen3_bit_clock, .serial_data_out_pin, .serial_data_out_en,
  .bit_clock_out_pin, .frame_clock_out_pin);
